// ---- core/ascr_map.vh ----
// register offsets, field positions, reset values and timing counts for the config block
`ifndef ASCR_MAP_VH
`define ASCR_MAP_VH
`define ASCR_ADDR_PWR        5'h00
`define ASCR_ADDR_CLKGAIN    5'h04
`define ASCR_ADDR_PATFMT     5'h0A
`define ASCR_ADDR_CUSTLO     5'h0B
`define ASCR_ADDR_FINEGAIN   5'h0C
`define ASCR_ADDR_IFACE      5'h0D
`define ASCR_ADDR_CLKDRV     5'h10
`define ASCR_ADDR_DATTERM    5'h11
`define ASCR_REG_RESET       11'h000
`define ASCR_BIT_SOFT_RESET  10
`define ASCR_BIT_OVERRIDE    10
`define ASCR_BIT_FORMAT      9
`define ASCR_WORD_BITS       16
`define ASCR_ADDR_BITS       5
`define ASCR_DATA_BITS       11
`define ASCR_CLK_PERIOD_NS   100
`define ASCR_EFFECT_NS       100
`define ASCR_RST_PULSE_NS    10
// longest time rounds down, never below one cycle
`define ASCR_EFFECT_CYC      ((`ASCR_EFFECT_NS / `ASCR_CLK_PERIOD_NS) < 1 ? 1 : \
                              (`ASCR_EFFECT_NS / `ASCR_CLK_PERIOD_NS))
// strap levels, as delivered by the level comparator: 0 gnd, 1 3/6, 2 5/6, 3 full
`define ASCR_LVL_GND         2'h0
`define ASCR_LVL_MID         2'h1
`define ASCR_LVL_HIGH        2'h2
`define ASCR_LVL_FULL        2'h3
`endif

// ---- core/ascr_sync.v ----
// two flip-flop synchroniser for a single asynchronous level
module ascr_sync (
    clk,
    rst_n,
    din,
    dout
);
    input  wire clk;
    input  wire rst_n;
    input  wire din;
    output wire dout;

    reg meta_ff;
    reg sync_ff;

    // first stage read only by the second
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule // ascr_sync

// ---- core/ascr_top.v ----
// serial configuration register bank of a quad-channel converter
// Functional notes
// - shifting accepted only while select is low
// - data sampled on each falling shift clock
// - sixteenth falling edge loads addressed register
// - leftover bits after last word are dropped
// - several words per select-low period allowed
// - five address bits then eleven data bits
// - write takes effect about 100 ns later; here outputs follow two clock cycles (200 ns) after the register load
// - reset pulse above 10 ns clears registers; here a pulse shorter than a clock period may be missed
// - soft reset bit clears all, self-clears
// - every register bit reads zero after reset
// - global and per-channel power down bits
// - clock buffer gain code decode
// - test pattern field selects output pattern
// - format bit: twos complement or binary
// - custom pattern msb from fine-gain register
// - fine gain in 1 dB steps to 6
// - lane count and ddr/sdr selection
// - override bit lets register beat straps
// - straps configure device after power-up
// - strap one decodes lanes and bit clock
// - strap two decodes serialization and edge
// - strap four decodes bit order and format
`include "ascr_map.vh"
module ascr_top (
    clk,
    resetn,
    hw_reset,
    serial_select_low,
    serial_shift_clk,
    serial_input_line,
    power_down_pin,
    strap_pin_one,
    strap_pin_two,
    strap_pin_four,
    global_power_down,
    channel_power_down,
    external_reference,
    clock_buffer_gain,
    gain_code_valid,
    test_pattern,
    output_number_format,
    custom_pattern,
    fine_gain_db,
    two_wire,
    sdr_bit_clock,
    serialize_14x,
    capture_rising,
    lsb_first,
    coarse_gain,
    bit_wise,
    clock_drive_cfg,
    data_term_cfg
);
    input  wire        clk;
    input  wire        resetn;
    input  wire        hw_reset;
    input  wire        serial_select_low;
    input  wire        serial_shift_clk;
    input  wire        serial_input_line;
    input  wire        power_down_pin;
    input  wire [1:0]  strap_pin_one;
    input  wire [1:0]  strap_pin_two;
    input  wire [1:0]  strap_pin_four;
    output reg         global_power_down;
    output reg  [3:0]  channel_power_down;
    output reg         external_reference;
    output reg  [2:0]  clock_buffer_gain;
    output reg         gain_code_valid;
    output reg  [2:0]  test_pattern;
    output reg         output_number_format;
    output reg  [11:0] custom_pattern;
    output reg  [2:0]  fine_gain_db;
    output reg         two_wire;
    output reg         sdr_bit_clock;
    output reg         serialize_14x;
    output reg         capture_rising;
    output reg         lsb_first;
    output reg         coarse_gain;
    output reg         bit_wise;
    output reg  [10:0] clock_drive_cfg;
    output reg  [10:0] data_term_cfg;

    localparam integer EFFECT_CYC_I = `ASCR_EFFECT_CYC;
    localparam [3:0]   EFFECT_CYC   = EFFECT_CYC_I[3:0];

    // gain code to gain step; invalid codes flagged
    function [3:0] gain_decode;
        input [4:0] code;
        begin
            case (code)
                5'h18:   gain_decode = 4'h8;
                5'h00:   gain_decode = 4'h9;
                5'h0C:   gain_decode = 4'hA;
                5'h0A:   gain_decode = 4'hB;
                5'h09:   gain_decode = 4'hC;
                5'h08:   gain_decode = 4'hD;
                default: gain_decode = 4'h1;
            endcase
        end
    endfunction

    // reset release through two flops
    reg rst_meta_ff;
    reg rst_n_ff;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // pin inputs synchronised before any logic
    wire sel_low_s;
    wire sck_s;
    wire sdi_s;
    wire hwr_s;
    wire pdn_s;
    wire [5:0] strap_s;
    ascr_sync u_sel (.clk(clk), .rst_n(rst_n_ff), .din(serial_select_low), .dout(sel_low_s));
    ascr_sync u_sck (.clk(clk), .rst_n(rst_n_ff), .din(serial_shift_clk), .dout(sck_s));
    ascr_sync u_sdi (.clk(clk), .rst_n(rst_n_ff), .din(serial_input_line), .dout(sdi_s));
    ascr_sync u_hwr (.clk(clk), .rst_n(rst_n_ff), .din(hw_reset), .dout(hwr_s));
    ascr_sync u_pdn (.clk(clk), .rst_n(rst_n_ff), .din(power_down_pin), .dout(pdn_s));
    ascr_sync u_s10 (.clk(clk), .rst_n(rst_n_ff), .din(strap_pin_one[0]), .dout(strap_s[0]));
    ascr_sync u_s11 (.clk(clk), .rst_n(rst_n_ff), .din(strap_pin_one[1]), .dout(strap_s[1]));
    ascr_sync u_s20 (.clk(clk), .rst_n(rst_n_ff), .din(strap_pin_two[0]), .dout(strap_s[2]));
    ascr_sync u_s21 (.clk(clk), .rst_n(rst_n_ff), .din(strap_pin_two[1]), .dout(strap_s[3]));
    ascr_sync u_s40 (.clk(clk), .rst_n(rst_n_ff), .din(strap_pin_four[0]), .dout(strap_s[4]));
    ascr_sync u_s41 (.clk(clk), .rst_n(rst_n_ff), .din(strap_pin_four[1]), .dout(strap_s[5]));

    // falling edge detect on the synchronised shift clock
    reg sck_d_ff;
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            sck_d_ff <= 1'b0;
        else
            sck_d_ff <= sck_s;
    end
    wire sck_fall = sck_d_ff & ~sck_s & ~sel_low_s;

    // shift register and bit counter
    reg  [15:0] shift_ff;
    reg  [3:0]  bitcnt_ff;
    reg  [15:0] nxt_shift;
    reg  [3:0]  nxt_bitcnt;
    reg         word_done;
    always @*
    begin
        nxt_shift  = shift_ff;
        nxt_bitcnt = bitcnt_ff;
        word_done  = 1'b0;
        if (sel_low_s)
            nxt_bitcnt = 4'h0; // partial word discarded on deselect
        else if (sck_fall)
        begin
            nxt_shift  = {shift_ff[14:0], sdi_s};
            nxt_bitcnt = bitcnt_ff + 4'h1;
            word_done  = (bitcnt_ff == 4'hF);
        end
    end
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            shift_ff  <= 16'h0000;
            bitcnt_ff <= 4'h0;
        end
        else
        begin
            shift_ff  <= nxt_shift;
            bitcnt_ff <= nxt_bitcnt;
        end
    end

    // a completed word: address high, data low
    wire [4:0]  w_addr = nxt_shift[15:11];
    wire [10:0] w_data = nxt_shift[10:0];

    // register file; hw pulse or soft reset bit clears all
    reg  [10:0] reg_pwr_ff;
    reg  [10:0] reg_clkgain_ff;
    reg  [10:0] reg_patfmt_ff;
    reg  [10:0] reg_custlo_ff;
    reg  [10:0] reg_fine_ff;
    reg  [10:0] reg_iface_ff;
    reg  [10:0] reg_clkdrv_ff;
    reg  [10:0] reg_datterm_ff;
    // hw reset sampled at 100 ns; the 10 ns minimum is below one cycle, so a
    // pulse shorter than a clock period may be missed
    wire soft_rst = word_done && (w_addr == `ASCR_ADDR_PWR) && w_data[`ASCR_BIT_SOFT_RESET];
    wire clear_all = hwr_s | soft_rst;
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            reg_pwr_ff     <= `ASCR_REG_RESET;
            reg_clkgain_ff <= `ASCR_REG_RESET;
            reg_patfmt_ff  <= `ASCR_REG_RESET;
            reg_custlo_ff  <= `ASCR_REG_RESET;
            reg_fine_ff    <= `ASCR_REG_RESET;
            reg_iface_ff   <= `ASCR_REG_RESET;
            reg_clkdrv_ff  <= `ASCR_REG_RESET;
            reg_datterm_ff <= `ASCR_REG_RESET;
        end
        else if (clear_all)
        begin
            // soft reset bit never stored, so it reads back zero
            reg_pwr_ff     <= `ASCR_REG_RESET;
            reg_clkgain_ff <= `ASCR_REG_RESET;
            reg_patfmt_ff  <= `ASCR_REG_RESET;
            reg_custlo_ff  <= `ASCR_REG_RESET;
            reg_fine_ff    <= `ASCR_REG_RESET;
            reg_iface_ff   <= `ASCR_REG_RESET;
            reg_clkdrv_ff  <= `ASCR_REG_RESET;
            reg_datterm_ff <= `ASCR_REG_RESET;
        end
        else if (word_done)
        begin
            // unknown addresses are dropped silently
            case (w_addr)
                `ASCR_ADDR_PWR:      reg_pwr_ff     <= w_data;
                `ASCR_ADDR_CLKGAIN:  reg_clkgain_ff <= w_data;
                `ASCR_ADDR_PATFMT:   reg_patfmt_ff  <= w_data;
                `ASCR_ADDR_CUSTLO:   reg_custlo_ff  <= w_data;
                `ASCR_ADDR_FINEGAIN: reg_fine_ff    <= w_data;
                `ASCR_ADDR_IFACE:    reg_iface_ff   <= w_data;
                `ASCR_ADDR_CLKDRV:   reg_clkdrv_ff  <= w_data;
                `ASCR_ADDR_DATTERM:  reg_datterm_ff <= w_data;
                default:             reg_pwr_ff     <= reg_pwr_ff;
            endcase
        end
    end

    // strap capture once after reset release
    reg        strap_done_ff;
    reg [1:0]  settle_ff;
    reg [5:0]  strap_ff;
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            strap_done_ff <= 1'b0;
            settle_ff     <= 2'h0;
            strap_ff      <= 6'h00;
        end
        else if (!strap_done_ff)
        begin
            // wait for synchronisers to fill before latching
            settle_ff <= settle_ff + 2'h1;
            if (settle_ff == 2'h3)
            begin
                strap_ff      <= strap_s;
                strap_done_ff <= 1'b1;
            end
        end
    end

    // effect delay: outputs follow the registers after the write settles
    reg [3:0] effect_cnt_ff;
    reg       apply_ff;
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            effect_cnt_ff <= 4'h0;
            apply_ff      <= 1'b1;
        end
        else if (word_done | hwr_s)
        begin
            effect_cnt_ff <= EFFECT_CYC;
            apply_ff      <= 1'b0;
        end
        else if (effect_cnt_ff > 4'h1)
            effect_cnt_ff <= effect_cnt_ff - 4'h1;
        else
        begin
            effect_cnt_ff <= 4'h0;
            apply_ff      <= 1'b1;
        end
    end

    // strap decode by level code, so on strap one the unused mid level falls to the ground meaning
    wire [1:0] lvl1   = strap_ff[1:0];
    wire [1:0] lvl2   = strap_ff[3:2];
    wire [1:0] lvl4   = strap_ff[5:4];
    wire       s_two  = (lvl1 == `ASCR_LVL_HIGH) | (lvl1 == `ASCR_LVL_FULL);
    wire       s_sdr  = (lvl1 == `ASCR_LVL_HIGH);
    wire       s_14x  = (lvl2 == `ASCR_LVL_MID) | (lvl2 == `ASCR_LVL_HIGH);
    wire       s_rise = (lvl2 == `ASCR_LVL_HIGH) | (lvl2 == `ASCR_LVL_FULL);
    wire       s_lsb  = (lvl4 == `ASCR_LVL_HIGH) | (lvl4 == `ASCR_LVL_FULL);
    wire       s_bin  = (lvl4 == `ASCR_LVL_MID) | (lvl4 == `ASCR_LVL_HIGH);

    wire       ovrd = reg_iface_ff[`ASCR_BIT_OVERRIDE];
    wire [3:0] gdec = gain_decode(reg_clkgain_ff[6:2]);

    // outputs registered, updated only once the write has settled
    always @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            global_power_down    <= 1'b0;
            channel_power_down   <= 4'h0;
            external_reference   <= 1'b0;
            clock_buffer_gain    <= 3'h1;
            gain_code_valid      <= 1'b1;
            test_pattern         <= 3'h0;
            output_number_format <= 1'b0;
            custom_pattern       <= 12'h000;
            fine_gain_db         <= 3'h0;
            two_wire             <= 1'b0;
            sdr_bit_clock        <= 1'b0;
            serialize_14x        <= 1'b0;
            capture_rising       <= 1'b0;
            lsb_first            <= 1'b0;
            coarse_gain          <= 1'b0;
            bit_wise             <= 1'b0;
            clock_drive_cfg      <= 11'h000;
            data_term_cfg        <= 11'h000;
        end
        else if (apply_ff)
        begin
            global_power_down    <= pdn_s | reg_pwr_ff[0];
            channel_power_down   <= reg_pwr_ff[4:1];
            external_reference   <= reg_pwr_ff[5];
            clock_buffer_gain    <= gdec[2:0];
            gain_code_valid      <= gdec[3];
            test_pattern         <= reg_patfmt_ff[7:5];
            custom_pattern       <= {reg_fine_ff[0], reg_custlo_ff};
            fine_gain_db         <= reg_fine_ff[10:8];
            clock_drive_cfg      <= reg_clkdrv_ff;
            data_term_cfg        <= reg_datterm_ff;
            if (ovrd)
            begin
                two_wire             <= reg_iface_ff[0];
                sdr_bit_clock        <= reg_iface_ff[0] & reg_iface_ff[1];
                serialize_14x        <= reg_iface_ff[2];
                capture_rising       <= reg_iface_ff[4];
                coarse_gain          <= reg_iface_ff[5];
                lsb_first            <= reg_iface_ff[6];
                bit_wise             <= reg_iface_ff[7];
                output_number_format <= reg_patfmt_ff[`ASCR_BIT_FORMAT];
            end
            else
            begin
                two_wire             <= s_two;
                sdr_bit_clock        <= s_sdr;
                serialize_14x        <= s_14x;
                capture_rising       <= s_rise;
                coarse_gain          <= 1'b0;
                lsb_first            <= s_lsb;
                bit_wise             <= 1'b0;
                output_number_format <= reg_patfmt_ff[`ASCR_BIT_FORMAT] | s_bin;
            end
        end
    end
endmodule // ascr_top

// ---- tb/ascr_top_assertions.sv ----
// property checker for the serial config register bank
module ascr_top_assertions (
    input wire        clk,
    input wire        resetn,
    input wire        hw_reset,
    input wire        serial_select_low,
    input wire        serial_shift_clk,
    input wire        power_down_pin,
    input wire        global_power_down,
    input wire [3:0]  channel_power_down,
    input wire [2:0]  clock_buffer_gain,
    input wire        gain_code_valid,
    input wire [2:0]  test_pattern,
    input wire [11:0] custom_pattern,
    input wire [2:0]  fine_gain_db
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       sclk_q_ff;
    logic [5:0] quiet_ff;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // cycles since a qualified falling shift edge or a hw reset; saturates
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_q_ff <= 1'b0;
            quiet_ff  <= 6'h00;
        end
        else
        begin
            sclk_q_ff <= serial_shift_clk;
            if (hw_reset || (sclk_q_ff && !serial_shift_clk && !serial_select_low))
                quiet_ff <= 6'h00;
            else if (quiet_ff != 6'h3F)
                quiet_ff <= quiet_ff + 6'h01;
        end
    end
    a_reset_defaults: assert property ($rose(resetn) |->
        custom_pattern == 12'h000 && fine_gain_db == 3'h0 &&
        clock_buffer_gain == 3'h1 && gain_code_valid == 1'b1)
        else $error("outputs not at defaults after reset");
    a_hw_clears: assert property (hw_reset [*3] |->
        ##[0:6] (custom_pattern == 12'h000 && test_pattern == 3'h0))
        else $error("hw reset did not clear registers");
    a_custom_cause: assert property ($changed(custom_pattern) |-> quiet_ff < 6'h0C)
        else $error("custom pattern changed without a shift edge");
    a_fine_cause: assert property ($changed(fine_gain_db) |-> quiet_ff < 6'h0C)
        else $error("fine gain changed without a shift edge");
    a_test_cause: assert property ($changed(test_pattern) |-> quiet_ff < 6'h0C)
        else $error("test pattern changed without a shift edge");
    a_idle_hold: assert property ((serial_select_low && !hw_reset) [*8] |=>
        $stable(channel_power_down))
        else $error("channel power down moved while deselected");
    a_pin_power: assert property (power_down_pin [*3] |-> ##[0:4] global_power_down == 1'b1)
        else $error("power down pin not honoured");
    a_gain_range: assert property (clock_buffer_gain <= 3'h5)
        else $error("clock buffer gain out of range");
    c_write: cover property ($changed(custom_pattern));
    c_hw: cover property (hw_reset [*3]);
    c_pin: cover property (power_down_pin [*3]);
endmodule // ascr_top_assertions

// ---- tb/ascr_host_model.sv ----
// host side model that shifts words into the serial config port
module ascr_host_model (
    output logic serial_select_low,
    output logic serial_shift_clk,
    output logic serial_input_line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF_NS = 400; // 800 ns link period
    // idle levels: select pulled up, clock and data pulled down, clock parked
    initial
    begin
        serial_select_low = 1'b1;
        serial_shift_clk  = 1'b0;
        serial_input_line = 1'b0;
    end
    // low n bits of v, msb first; sel_on clear shifts with select released
    task automatic send(input logic [47:0] v, input int n, input bit sel_on);
        serial_select_low = !sel_on;
        #HALF_NS;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_input_line = v[i];
            serial_shift_clk  = 1'b1;
            #HALF_NS;
            serial_shift_clk  = 1'b0;
            #HALF_NS;
        end
        serial_input_line = 1'b0;
        serial_select_low = 1'b1;
        #HALF_NS;
    endtask
endmodule // ascr_host_model

// ---- tb/ascr_top_tb.sv ----
// self-checking bench for the serial config register bank
module ascr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [15:0] w; int id; logic [11:0] e;} ascr_row_t;
    logic        clk, resetn, hw_reset, power_down_pin;
    logic        serial_select_low, serial_shift_clk, serial_input_line;
    logic [1:0]  strap_pin_one, strap_pin_two, strap_pin_four;
    logic        global_power_down, external_reference, gain_code_valid, output_number_format;
    logic        two_wire, sdr_bit_clock, serialize_14x, capture_rising, lsb_first;
    logic        coarse_gain, bit_wise;
    logic [3:0]  channel_power_down;
    logic [2:0]  clock_buffer_gain, test_pattern, fine_gain_db;
    logic [11:0] custom_pattern;
    logic [10:0] clock_drive_cfg, data_term_cfg;
    int          mismatches = 0;
    int          tests_run = 0;
    ascr_row_t   rows[$];
    logic [11:0] strap_exp[4] = '{12'h000, 12'h004, 12'h02F, 12'h029};
    logic        fmt_exp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    ascr_top uut (.clk, .resetn, .hw_reset, .serial_select_low, .serial_shift_clk,
        .serial_input_line, .power_down_pin, .strap_pin_one, .strap_pin_two,
        .strap_pin_four, .global_power_down, .channel_power_down, .external_reference,
        .clock_buffer_gain, .gain_code_valid, .test_pattern, .output_number_format,
        .custom_pattern, .fine_gain_db, .two_wire, .sdr_bit_clock, .serialize_14x,
        .capture_rising, .lsb_first, .coarse_gain, .bit_wise, .clock_drive_cfg,
        .data_term_cfg);
    ascr_host_model host (.serial_select_low, .serial_shift_clk, .serial_input_line);

    // 10 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // output groups gathered into one comparable value
    function automatic logic [11:0] obs(input int id);
        case (id)
            0: obs = custom_pattern;
            1: obs = {9'h000, fine_gain_db};
            2: obs = {8'h00, gain_code_valid, clock_buffer_gain};
            3: obs = {9'h000, test_pattern};
            4: obs = {6'h00, external_reference, channel_power_down, global_power_down};
            5: obs = {11'h000, output_number_format};
            6: obs = {5'h00, bit_wise, lsb_first, coarse_gain, capture_rising,
                      serialize_14x, sdr_bit_clock, two_wire};
            7: obs = {1'h0, clock_drive_cfg};
            default: obs = {1'h0, data_term_cfg};
        endcase
    endfunction

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one frame, then room for the write to reach the outputs
    task automatic put(input logic [47:0] v, input int n, input bit s);
        host.send(v, n, s);
        cyc(8);
    endtask

    task automatic tally_and_finish;
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        resetn = 1'b0;
        hw_reset = 1'b0;
        power_down_pin = 1'b0;
        strap_pin_one = 2'h0;
        strap_pin_two = 2'h0;
        strap_pin_four = 2'h0;
        rows = '{
            '{16'h5955, 0, 12'h155}, '{16'h6601, 0, 12'h955},
            '{16'h6601, 1, 12'h006},
            '{16'h2060, 2, 12'h008}, '{16'h2000, 2, 12'h009}, '{16'h2030, 2, 12'h00A},
            '{16'h2028, 2, 12'h00B}, '{16'h2024, 2, 12'h00C}, '{16'h2020, 2, 12'h00D},
            '{16'h2004, 2, 12'h001}, '{16'h2000, 2, 12'h009},
            '{16'h003F, 4, 12'h03F}, '{16'h0000, 4, 12'h000},
            '{16'h5200, 5, 12'h001}, '{16'h5000, 5, 12'h000},
            '{16'h6CF7, 6, 12'h07F},
            '{16'h85A5, 7, 12'h5A5}, '{16'h8E1F, 8, 12'h61F}};
        for (int k = 0; k < 8; k++)
            rows.push_back('{{5'h0A, 3'h0, k[2:0], 5'h00}, 3, {9'h000, k[2:0]}});
        cyc(6);
        resetn = 1'b1;
        cyc(10);
        foreach (rows[i])
        begin
            put({32'h0, rows[i].w}, 16, 1'b1);
            chk(obs(rows[i].id), rows[i].e);
        end
        // two words in one frame
        put({16'h0, 16'h5923, 16'h8246}, 32, 1'b1);
        chk(obs(0), 12'h923);
        chk(obs(7), 12'h246);
        // trailing bits must neither land nor leak into the next frame
        put({28'h0, 16'h58AA, 4'hF}, 20, 1'b1);
        chk(obs(0), 12'h8AA);
        chk(obs(8), 12'h61F);
        put({32'h0, 16'h5911}, 16, 1'b1);
        chk(obs(0), 12'h911);
        // shifting with select released is ignored
        put({32'h0, 16'h5FFF}, 16, 1'b0);
        chk(obs(0), 12'h911);
        // soft reset clears all and lets later writes stick
        put({32'h0, 16'h0400}, 16, 1'b1);
        chk(obs(0), 12'h000);
        chk(obs(2), 12'h009);
        chk(obs(7), 12'h000);
        put({32'h0, 16'h58AA}, 16, 1'b1);
        chk(obs(0), 12'h0AA);
        hw_reset = 1'b1;
        cyc(3);
        hw_reset = 1'b0;
        cyc(8);
        chk(obs(0), 12'h000);
        power_down_pin = 1'b1;
        cyc(8);
        chk(obs(4), 12'h001);
        power_down_pin = 1'b0;
        cyc(8);
        chk(obs(4), 12'h000);
        // a register left set, so the first mid-run reset has something to clear
        put({32'h0, 16'h58AA}, 16, 1'b1);
        // straps sampled after each reset release, override clear
        for (int k = 0; k < 4; k++)
        begin
            strap_pin_one = k[1:0];
            strap_pin_two = k[1:0];
            strap_pin_four = k[1:0];
            resetn = 1'b0;
            cyc(2);
            resetn = 1'b1;
            cyc(12);
            chk(obs(6), strap_exp[k]);
            chk(obs(5), {11'h000, fmt_exp[k]});
            chk(obs(0), 12'h000);
        end
        tally_and_finish();
    end
endmodule // ascr_top_tb

bind ascr_top ascr_top_assertions chk_i (.clk, .resetn, .hw_reset, .serial_select_low,
    .serial_shift_clk, .power_down_pin, .global_power_down, .channel_power_down,
    .clock_buffer_gain, .gain_code_valid, .test_pattern, .custom_pattern, .fine_gain_db);
